// *** sdt_defs.svh ***
// register map, field positions, reset values and fixed codes
`ifndef SDT_DEFS_SVH
`define SDT_DEFS_SVH
`define SDT_CTRL_OFS    8'h00
`define SDT_STAT_OFS    8'h04
`define SDT_CTRL_RST    8'h00
`define SDT_CKSEL_LSB   0
`define SDT_HALF_BIT    2
`define SDT_PARITY_CONTROL_LSB  3
`define SDT_LOOP_BIT    5
`define SDT_SPEED_LSB   6
`define SDT_INVALID     10'h278
`define SDT_LFSR_SEED   9'h1ff
`define SDT_INIT_FILL   2
`define SDT_INIT_SAMPLES 2'h2
`define SDT_MULT_FULL   5'h0a
`define SDT_MULT_HALF   5'h14
`define SDT_SYNC_W      62
`endif

// *** sdt_pkg.sv ***
// types shared by the serializer transmit path
package sdt_pkg;
  typedef enum logic [1:0] {
    SDT_LOW  = 2'b00,
    SDT_MID  = 2'b01,
    SDT_HIGH = 2'b10
  } sdt_level_t;
  typedef enum logic [1:0] {
    SDT_ALN_INIT  = 2'b00,
    SDT_ALN_RUN   = 2'b01,
    SDT_ALN_FAULT = 2'b10
  } sdt_aln_t;
  typedef logic [9:0]      sdt_char_t;
  typedef logic [3:0][9:0] sdt_lane_chars_t;
endpackage

// *** sdt_tx_path.sv ***
// transmit path of a four-lane serializer with an ahb-lite register slave
//
// How it works
// - input clock: reference, shared, or lane clock
// - capture ten bits, parity when checking enabled
// - bit 0 first out, bit 9 last
// - reference clock full rate bypasses align buffer
// - other clocking or half rate uses buffer
// - init after two low samples, phase set on release
// - buffer tolerates two characters of drift either way
// - phase error sticks until buffer reinitialised
// - phase error sends invalid character continuously
// - parity control low disables, else checks odd
// - parity error replaces character with invalid
// - self-test lfsr repeats 511 characters
// - self-test latch transparent high, holds low
// - device reset disables self-test on all lanes
// - self-test ignores character and parity inputs
// - odd bus bits self-test, even bits enables
// - loopback drives static one on enabled outputs
// - output latch transparent high, holds low
// - device reset disables every output driver
// - multiplier ten or twenty, character-rate tick
`timescale 1ns/100ps
`include "sdt_defs.svh"
module sdt_tx_path #(
  parameter int DEPTH = 4
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic                    reference_clock,
  input  wire logic                    shared_tx_clock,
  input  wire logic [3:0]              lane_tx_clock,
  input  wire sdt_pkg::sdt_lane_chars_t tx_char_in,
  input  wire logic [3:0]              tx_parity_in,
  input  wire logic                    align_buffer_init_n,
  input  wire logic [7:0]              shared_enable_bus,
  input  wire logic                    selftest_latch_enable,
  input  wire logic                    output_latch_enable,
  input  wire logic                    device_reset_n,
  output sdt_pkg::sdt_lane_chars_t     serial_out_char,
  output logic      [3:0]              serial_out_stb,
  output logic      [3:0]              serial_out_one,
  output logic      [3:0]              serial_out_en,
  output logic      [3:0]              tx_phase_error
);
  import sdt_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // every non-ahb input pin passes two flops; the second stage is read, and the six clock pins also pass a third for edge detection
  logic [`SDT_SYNC_W-1:0] s1_ff, s2_ff;
  logic [5:0]             prev_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      prev_ff <= '0;
    end else begin
      s1_ff   <= {tx_parity_in, tx_char_in, shared_enable_bus,
                  output_latch_enable, selftest_latch_enable,
                  device_reset_n, align_buffer_init_n, lane_tx_clock,
                  shared_tx_clock, reference_clock};
      s2_ff   <= s1_ff;
      prev_ff <= s2_ff[5:0];
    end
  end

  logic        ref_rise, ref_fall, sh_rise, s_init, s_devrst;
  logic        s_stle, s_output_latch_enable;
  logic [3:0]  ln_rise, s_par;
  logic [7:0]  s_bus;
  logic [39:0] s_chr;
  assign ref_rise = s2_ff[0] & ~prev_ff[0];
  assign ref_fall = ~s2_ff[0] & prev_ff[0];
  assign sh_rise  = s2_ff[1] & ~prev_ff[1];
  assign ln_rise  = s2_ff[5:2] & ~prev_ff[5:2];
  assign s_init   = s2_ff[6];
  assign s_devrst = s2_ff[7];
  assign s_stle   = s2_ff[8];
  assign s_output_latch_enable   = s2_ff[9];
  assign s_bus    = s2_ff[17:10];
  assign s_chr    = s2_ff[57:18];
  assign s_par    = s2_ff[61:58];

  // ahb-lite slave: zero wait, write lands in the data phase
  logic [7:0]  ctrl_ff, nxt_ctrl, waddr_ff, nxt_waddr;
  logic        wpend_ff, nxt_wpend, hready_ff;
  logic [31:0] hrdata_ff, nxt_hrdata, stat;
  logic        acc;
  always_comb begin
    acc        = hsel & htrans[1] & hready;
    nxt_wpend  = acc & hwrite;
    nxt_waddr  = haddr[7:0];
    nxt_ctrl   = ctrl_ff;
    if (wpend_ff && waddr_ff == `SDT_CTRL_OFS)
      nxt_ctrl = hwdata[7:0];
    nxt_hrdata = '0;  // unmapped reads give zero, still okay
    if (acc && !hwrite) begin
      // read right after a write sees the new control value
      if (haddr[7:0] == `SDT_CTRL_OFS)
        nxt_hrdata = {24'h0, nxt_ctrl};
      else if (haddr[7:0] == `SDT_STAT_OFS)
        nxt_hrdata = stat;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= `SDT_CTRL_RST;
      waddr_ff  <= '0;
      wpend_ff  <= 1'b0;
      hrdata_ff <= '0;
      hready_ff <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      waddr_ff  <= nxt_waddr;
      wpend_ff  <= nxt_wpend;
      hrdata_ff <= nxt_hrdata;
      hready_ff <= 1'b1;
    end
  end
  assign hrdata    = hrdata_ff;
  assign hreadyout = hready_ff;  // no wait states once out of reset
  assign hresp     = 1'b0;

  // decoded control; the host keeps illegal combinations away
  logic       sel_low, sel_mid, half, par_en, loop, bypass, tick;
  logic [1:0] speed;  // stored for software only
  logic [4:0] mult;
  assign sel_low = ctrl_ff[`SDT_CKSEL_LSB +: 2] == SDT_LOW;
  assign sel_mid = ctrl_ff[`SDT_CKSEL_LSB +: 2] == SDT_MID;
  assign half    = ctrl_ff[`SDT_HALF_BIT];
  assign par_en  = ctrl_ff[`SDT_PARITY_CONTROL_LSB +: 2] != SDT_LOW;
  assign loop    = ctrl_ff[`SDT_LOOP_BIT];
  assign speed   = ctrl_ff[`SDT_SPEED_LSB +: 2];
  assign bypass  = sel_low & ~half;
  assign tick    = ref_rise | (half & ref_fall);
  assign mult    = half ? `SDT_MULT_HALF : `SDT_MULT_FULL;

  // enable latches, transparent while their enable is high
  logic [3:0] st_lat_ff, nxt_st_lat, oe_lat_ff, nxt_oe_lat, st_on;
  always_comb begin
    nxt_st_lat = st_lat_ff;
    nxt_oe_lat = oe_lat_ff;
    if (!s_devrst) begin
      nxt_st_lat = 4'hf;
      nxt_oe_lat = 4'h0;
    end else begin
      if (s_stle)
        nxt_st_lat = {s_bus[7], s_bus[5], s_bus[3], s_bus[1]};
      if (s_output_latch_enable)
        nxt_oe_lat = {s_bus[6], s_bus[4], s_bus[2], s_bus[0]};
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_lat_ff <= 4'hf;
      oe_lat_ff <= 4'h0;
    end else begin
      st_lat_ff <= nxt_st_lat;
      oe_lat_ff <= nxt_oe_lat;
    end
  end
  assign st_on = ~st_lat_ff;  // a low latched bit runs the generator

  // init request: two low samples on reference rising edges
  logic [1:0] lowc_ff, nxt_lowc;
  logic       init_act;
  always_comb begin
    nxt_lowc = lowc_ff;
    if (s_init)
      nxt_lowc = 2'h0;  // release fixes the phase at once
    else if (ref_rise && lowc_ff != `SDT_INIT_SAMPLES)
      nxt_lowc = lowc_ff + 2'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      lowc_ff <= 2'h0;
    else
      lowc_ff <= nxt_lowc;
  end
  assign init_act = lowc_ff == `SDT_INIT_SAMPLES;

  // per-lane capture, phase-align buffer, checks and character select
  logic [10:0]     buf_ff [4][DEPTH], nxt_buf [4][DEPTH];
  logic [AW-1:0]   wp_ff [4], nxt_wp [4], rp_ff [4], nxt_rp [4];
  logic [AW:0]     cnt_ff [4], nxt_cnt [4];
  sdt_aln_t        aln_ff [4], nxt_aln [4];
  logic [10:0]     byp_ff [4], nxt_byp [4];
  logic [8:0]      lfsr_ff [4], nxt_lfsr [4];
  sdt_lane_chars_t och_ff, nxt_och;
  logic [3:0]      stb_ff, nxt_stb, one_ff, nxt_one, en_ff, nxt_en;
  logic [3:0]      perr_ff, nxt_perr;
  always_comb begin
    logic [10:0] din;
    logic [10:0] src;
    logic        cap, rd, wr;
    din = '0; src = '0; cap = 1'b0; rd = 1'b0; wr = 1'b0;
    nxt_buf = buf_ff;   nxt_wp = wp_ff;     nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;   nxt_aln = aln_ff;   nxt_byp = byp_ff;
    nxt_lfsr = lfsr_ff; nxt_och = och_ff;
    nxt_stb = '0;       nxt_one = '0;       nxt_en = oe_lat_ff;
    for (int i = 0; i < 4; i++) begin
      // capture edge follows the clock selection
      cap = sel_low ? tick : (sel_mid ? ln_rise[i] : sh_rise);
      // parity bit kept only when checking is on
      din = {par_en & s_par[i], s_chr[i*10 +: 10]};
      wr  = cap & ~bypass & ~st_on[i];
      rd  = tick & ~bypass;
      if (cap && bypass && !st_on[i])
        nxt_byp[i] = din;
      case (aln_ff[i])
        SDT_ALN_INIT: begin
          // half full gives two characters of slack each way
          nxt_wp[i]  = AW'(`SDT_INIT_FILL);
          nxt_rp[i]  = '0;
          nxt_cnt[i] = (AW+1)'(`SDT_INIT_FILL);
          if (!init_act)
            nxt_aln[i] = SDT_ALN_RUN;
        end
        SDT_ALN_RUN: begin
          if (init_act)
            nxt_aln[i] = SDT_ALN_INIT;
          else if ((rd && cnt_ff[i] == '0) ||
                   (wr && !rd && cnt_ff[i] == (AW+1)'(DEPTH)))
            nxt_aln[i] = SDT_ALN_FAULT;
          else begin
            if (wr) begin
              nxt_buf[i][wp_ff[i]] = din;
              nxt_wp[i] = AW'(wp_ff[i] + 1'b1);
            end
            if (rd)
              nxt_rp[i] = AW'(rp_ff[i] + 1'b1);
            if (wr && !rd)
              nxt_cnt[i] = cnt_ff[i] + 1'b1;
            else if (rd && !wr)
              nxt_cnt[i] = cnt_ff[i] - 1'b1;
          end
        end
        SDT_ALN_FAULT: begin
          if (init_act)
            nxt_aln[i] = SDT_ALN_INIT;  // only reinit clears it
        end
        default: nxt_aln[i] = SDT_ALN_INIT;
      endcase
      src = bypass ? byp_ff[i] : buf_ff[i][rp_ff[i]];
      if (tick && st_on[i])
        nxt_lfsr[i] = {lfsr_ff[i][7:0],
                       lfsr_ff[i][8] ^ lfsr_ff[i][4]};
      // a powered-down lane holds its last character
      if (tick && oe_lat_ff[i]) begin
        nxt_stb[i] = 1'b1;
        if (loop) begin
          nxt_och[i] = 10'h3ff;
          nxt_one[i] = 1'b1;
        end else if (st_on[i])
          nxt_och[i] = {lfsr_ff[i][8] ^ lfsr_ff[i][0],
                        lfsr_ff[i]};
        else if (aln_ff[i] == SDT_ALN_FAULT)
          nxt_och[i] = `SDT_INVALID;
        else if (par_en && !(^src))
          nxt_och[i] = `SDT_INVALID;
        else
          nxt_och[i] = src[9:0];  // bit 0 leaves first
      end
      nxt_perr[i] = nxt_aln[i] == SDT_ALN_FAULT;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        for (int j = 0; j < DEPTH; j++)
          buf_ff[i][j] <= '0;
        wp_ff[i]   <= AW'(`SDT_INIT_FILL);
        rp_ff[i]   <= '0;
        cnt_ff[i]  <= (AW+1)'(`SDT_INIT_FILL);
        aln_ff[i]  <= SDT_ALN_RUN;
        byp_ff[i]  <= '0;
        lfsr_ff[i] <= `SDT_LFSR_SEED;
      end
      och_ff  <= '0;
      stb_ff  <= '0;
      one_ff  <= '0;
      en_ff   <= '0;
      perr_ff <= '0;
    end else begin
      buf_ff  <= nxt_buf;
      wp_ff   <= nxt_wp;
      rp_ff   <= nxt_rp;
      cnt_ff  <= nxt_cnt;
      aln_ff  <= nxt_aln;
      byp_ff  <= nxt_byp;
      lfsr_ff <= nxt_lfsr;
      och_ff  <= nxt_och;
      stb_ff  <= nxt_stb;
      one_ff  <= nxt_one;
      en_ff   <= nxt_en;
      perr_ff <= nxt_perr;
    end
  end
  assign serial_out_char = och_ff;
  assign serial_out_stb  = stb_ff;
  assign serial_out_one  = one_ff;
  assign serial_out_en   = en_ff;
  assign tx_phase_error  = perr_ff;
  assign stat = {13'h0, speed, mult, oe_lat_ff, st_on, perr_ff};

  // checks on lane 0; the other lanes share the same logic
  sequence s_tick0;
    tick && oe_lat_ff[0] && !loop;
  endsequence
  sequence s_data0;
    s_tick0 ##0 !st_on[0] && aln_ff[0] != SDT_ALN_FAULT && bypass;
  endsequence
  property p_fault_char;
    @(posedge hclk) disable iff (!hresetn)
      s_tick0 ##0 !st_on[0] && aln_ff[0] == SDT_ALN_FAULT |=>
      serial_out_stb[0] && serial_out_char[0] == `SDT_INVALID;
  endproperty
  a_fault_char: assert property (p_fault_char)
    else $error("phase fault did not send invalid character");
  property p_fault_sticky;
    @(posedge hclk) disable iff (!hresetn)
      aln_ff[0] == SDT_ALN_FAULT && !init_act |=>
      tx_phase_error[0];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("phase error dropped without reinit");
  property p_init;
    @(posedge hclk) disable iff (!hresetn)
      !s_init && ref_rise && lowc_ff == 2'h1 |=>
      init_act ##1 aln_ff[0] == SDT_ALN_INIT && !tx_phase_error[0];
  endproperty
  a_init: assert property (p_init)
    else $error("two low samples did not initialise buffer");
  property p_devrst;
    @(posedge hclk) disable iff (!hresetn)
      !s_devrst |=> st_lat_ff == 4'hf && oe_lat_ff == 4'h0;
  endproperty
  a_devrst: assert property (p_devrst)
    else $error("device reset did not preset latches");
  property p_st_hold;
    @(posedge hclk) disable iff (!hresetn)
      s_devrst && !s_stle |=> $stable(st_lat_ff);
  endproperty
  a_st_hold: assert property (p_st_hold)
    else $error("self-test latch changed while closed");
  property p_oe_pass;
    @(posedge hclk) disable iff (!hresetn)
      s_devrst && s_output_latch_enable |-> ##2 serial_out_en[0] == $past(s_bus[0], 2);
  endproperty
  a_oe_pass: assert property (p_oe_pass)
    else $error("output latch did not pass enable bus");
  property p_loop;
    @(posedge hclk) disable iff (!hresetn)
      tick && loop && oe_lat_ff[0] |=>
      serial_out_one[0] && serial_out_char[0] == 10'h3ff;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback did not drive static one");
  property p_parity;
    @(posedge hclk) disable iff (!hresetn)
      s_data0 ##0 par_en && !(^byp_ff[0]) |=>
      serial_out_char[0] == `SDT_INVALID;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity error not replaced");
  property p_pass;
    @(posedge hclk) disable iff (!hresetn)
      s_data0 ##0 (!par_en || ^byp_ff[0]) |=>
      serial_out_char[0] == $past(byp_ff[0][9:0]);
  endproperty
  a_pass: assert property (p_pass)
    else $error("captured character not passed through");
  property p_lfsr;
    @(posedge hclk) disable iff (!hresetn)
      s_tick0 ##0 st_on[0] |=> serial_out_char[0] ==
      $past({lfsr_ff[0][8] ^ lfsr_ff[0][0], lfsr_ff[0]});
  endproperty
  a_lfsr: assert property (p_lfsr)
    else $error("self-test lane did not send generator value");
endmodule // sdt_tx_path

// *** sdt_host_model.sv ***
// host-side model: lane characters plus the shared and lane capture clocks
`timescale 1ns/100ps
module sdt_host_model (
  input  wire logic                 reference_clock,
  input  wire logic [9:0]           want_char,
  input  wire logic                 want_par,
  input  wire logic                 fast_clock,
  output sdt_pkg::sdt_lane_chars_t  tx_char_in,
  output logic      [3:0]           tx_parity_in,
  output logic                      shared_tx_clock,
  output logic      [3:0]           lane_tx_clock
);
  import sdt_pkg::*;
  logic lane_dly;

  // data moves half a reference period away from its capture edge
  initial begin
    tx_char_in   = '0;
    tx_parity_in = 4'h0;
  end
  always @(negedge reference_clock) begin
    tx_char_in   <= {4{want_char}};
    tx_parity_in <= {4{want_par}};
  end

  // character-rate clocks only; never used with half rate
  // fast_clock runs them too quickly so the align buffer overruns
  initial begin
    shared_tx_clock = 1'b0;
    #21;
    forever #(fast_clock ? 35 : 40) shared_tx_clock = ~shared_tx_clock;
  end
  always @(shared_tx_clock) lane_dly <= #10 shared_tx_clock;
  assign lane_tx_clock = {4{lane_dly}};
endmodule // sdt_host_model

// *** tb_top.sv ***
// self-checking bench for the serializer transmit path
`timescale 1ns/100ps
module tb_top;
  import sdt_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [9:0] ch;
    logic       par;
    logic [9:0] exp;
    logic       one;
  } sdt_row_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, reference_clock = 0;
  logic [31:0]     haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]      htrans = 0;
  logic            hreadyout, hresp, fast_clock = 0, want_par = 0;
  logic            align_buffer_init_n = 1, device_reset_n = 0;
  logic            selftest_latch_enable = 1, output_latch_enable = 1;
  logic [7:0]      shared_enable_bus = 8'hff;
  logic [9:0]      want_char = 0, first;
  logic [3:0]      tx_parity_in, lane_tx_clock, serial_out_stb;
  logic [3:0]      serial_out_one, serial_out_en, tx_phase_error;
  logic            shared_tx_clock;
  sdt_lane_chars_t tx_char_in, serial_out_char;
  int              err_total = 0, checks_done = 0, hits;
  sdt_row_t rows [10] = '{
    '{8'h08, 10'h001, 1'b0, 10'h001, 1'b0},
    '{8'h08, 10'h001, 1'b1, 10'h278, 1'b0},
    '{8'h10, 10'h3ff, 1'b0, 10'h278, 1'b0},
    '{8'h10, 10'h3ff, 1'b1, 10'h3ff, 1'b0},
    '{8'h00, 10'h2a5, 1'b1, 10'h2a5, 1'b0},
    '{8'h20, 10'h123, 1'b0, 10'h3ff, 1'b1},
    '{8'h44, 10'h30c, 1'b0, 10'h30c, 1'b0},
    '{8'h81, 10'h155, 1'b1, 10'h155, 1'b0},
    '{8'h0a, 10'h0f0, 1'b1, 10'h0f0, 1'b0},
    '{8'h02, 10'h0f0, 1'b0, 10'h0f0, 1'b0}};

  // system clock, and a link clock with unrelated phase
  always #5 hclk = ~hclk;
  initial begin
    #3.3;
    forever #40 reference_clock = ~reference_clock;
  end

  sdt_tx_path #(.DEPTH(4)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reference_clock(reference_clock),
    .shared_tx_clock(shared_tx_clock), .lane_tx_clock(lane_tx_clock),
    .tx_char_in(tx_char_in), .tx_parity_in(tx_parity_in),
    .align_buffer_init_n(align_buffer_init_n),
    .shared_enable_bus(shared_enable_bus),
    .selftest_latch_enable(selftest_latch_enable),
    .output_latch_enable(output_latch_enable),
    .device_reset_n(device_reset_n), .serial_out_char(serial_out_char),
    .serial_out_stb(serial_out_stb), .serial_out_one(serial_out_one),
    .serial_out_en(serial_out_en), .tx_phase_error(tx_phase_error));

  sdt_host_model host (
    .reference_clock(reference_clock), .want_char(want_char),
    .want_par(want_par), .fast_clock(fast_clock),
    .tx_char_in(tx_char_in), .tx_parity_in(tx_parity_in),
    .shared_tx_clock(shared_tx_clock), .lane_tx_clock(lane_tx_clock));

  task automatic chk(input string what, input logic [39:0] exp,
                     input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ready is sampled at each rising edge, before the slave updates it
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100) err_total++;
  endtask

  // one single word transfer; read data taken at the closing edge
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask

  // bounded wait for a character strobe on one lane
  task automatic wait_stb(input int lane);
    int n;
    n = 0;
    @(negedge hclk);
    while (serial_out_stb[lane] !== 1'b1 && n < 60) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 60) err_total++;
  endtask

  // hold the init pin low across several reference edges
  task automatic buf_init;
    @(posedge hclk);
    align_buffer_init_n <= 1'b0;
    repeat (40) @(posedge hclk);
    align_buffer_init_n <= 1'b1;
    repeat (40) @(posedge hclk);
  endtask

  task automatic end_sim;
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog against a hung handshake or a missing strobe
  initial begin
    #800000;
    err_total++;
    end_sim;
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl reset", 40'h0, {8'h0, rd});
    chk("drivers in reset", 40'h0, {36'h0, serial_out_en});
    @(posedge hclk);
    device_reset_n <= 1'b1;
    repeat (10) @(posedge hclk);
    // ordinary cases: one mode per row
    foreach (rows[i]) begin
      want_char <= rows[i].ch;
      want_par  <= rows[i].par;
      ahb(1'b1, 32'h0, {24'h0, rows[i].ctrl});
      if (rows[i].ctrl[2:0] != 3'b000) buf_init;
      repeat (6) wait_stb(0);
      chk("chars", {4{rows[i].exp}}, serial_out_char);
      chk("one", {36'h0, {4{rows[i].one}}}, {36'h0, serial_out_one});
      ahb(1'b0, 32'h4, 32'h0);
      chk("status", {8'h0, 13'h0, rows[i].ctrl[7:6],
          rows[i].ctrl[2] ? 5'h14 : 5'h0a, 12'hf00}, {8'h0, rd});
    end
    // capture clock overruns the buffer: sticky fault and error code
    fast_clock <= 1'b1;
    repeat (40) wait_stb(0);
    chk("phase fault", 40'hf, {36'h0, tx_phase_error});
    chk("fault chars", {4{10'h278}}, serial_out_char);
    fast_clock <= 1'b0;
    repeat (20) wait_stb(0);
    chk("fault sticks", 40'hf, {36'h0, tx_phase_error});
    buf_init;
    repeat (6) wait_stb(0);
    chk("fault cleared", 40'h0, {36'h0, tx_phase_error});
    chk("data back", {4{10'h0f0}}, serial_out_char);
    // self-test on lane a, latched then the bus released
    ahb(1'b1, 32'h0, 32'h0);
    @(posedge hclk);
    shared_enable_bus <= 8'hfd;
    repeat (20) @(posedge hclk);
    selftest_latch_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    shared_enable_bus <= 8'hff;
    repeat (20) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0);
    chk("selftest held", 40'h1, {36'h0, rd[7:4]});
    wait_stb(0);
    first = serial_out_char[0];
    hits = 0;
    for (int k = 1; k < 511; k++) begin
      if (k == 100) want_par <= 1'b1;
      wait_stb(0);
      if (serial_out_char[0] === first) hits++;
    end
    chk("no early repeat", 40'h0, 40'(hits));
    wait_stb(0);
    chk("period", {30'h0, first}, {30'h0, serial_out_char[0]});
    // device reset presets both latches
    @(posedge hclk);
    device_reset_n <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, 32'h4, 32'h0);
    chk("selftest off", 40'h0, {36'h0, rd[7:4]});
    chk("drivers off", 40'h0, {36'h0, serial_out_en});
    device_reset_n <= 1'b1;
    // lane a driver off through the output latch, then held
    shared_enable_bus <= 8'hfe;
    repeat (20) @(posedge hclk);
    output_latch_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    shared_enable_bus <= 8'hff;
    repeat (20) @(posedge hclk);
    chk("latched enables", 40'he, {36'h0, serial_out_en});
    wait_stb(1);
    chk("disabled lane quiet", 40'h0, {39'h0, serial_out_stb[0]});
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped read", 40'h0, {8'h0, rd});
    end_sim;
  end
endmodule // tb_top
